// ===== hw/cep_profile_status.sv
// How it works
// - Load settings from memory for applied profile
// - Host register writes never change contents
// - Stimulus 3 frozen for legacy, SDP, DCP
// - Legacy in charger cycle freezes BC1.2 controls
// - Sleep clears first config of each stimulus
// - Other config registers survive Sleep
// - Profile register rewritten on change, cleared in Sleep
// - Active profile shown as 4-bit code
// - Timer mode 1: apply, hold, remove if gone
// - Timer mode 0: delay before response
// - Delay code selects 0 to 100 ms
// - Bus voltage stimuli advance without removal
// - Select codes 001, 011 and 110 detect data line above threshold
// - Select 010 is positive line window comparator
// - Unusable response values are rejected on load
// - Voltage responses use magnitude as voltage
// - Resistor responses use magnitude as resistance
// - Divider responses use magnitude as divider total
// - Response register: magnitude high, code low, 26h
// - Response code selects the data-line action
`timescale 1ns/1ps

module cep_profile_status #(
  parameter int unsigned MS_CYCLES = cep_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk,              // 20 MHz clock
  input  wire logic       i_rst,              // Async reset, active high
  // Host register access
  input  wire logic       i_reg_rd,           // Register read strobe
  input  wire logic       i_reg_wr,           // Register write strobe
  input  wire logic [7:0] i_reg_addr,         // Register address
  input  wire logic [7:0] i_reg_wdata,        // Write data, discarded
  output logic      [7:0] o_reg_rdata,        // Read data
  output logic            o_reg_ack,          // Access done pulse
  // Profile selection and memory loader
  input  wire logic       i_profile_apply,    // Profile change pulse
  input  wire logic [3:0] i_profile_code,     // Code of new profile
  input  wire logic       i_dce_cycle,        // Dedicated charger cycle running
  input  wire logic       i_ld_en,            // Memory loader write strobe
  input  wire logic [7:0] i_ld_addr,          // Loader target address
  input  wire logic [7:0] i_ld_data,          // Loader data
  output logic            o_ld_reject,        // Loader write refused pulse
  // Sleep and first stimulus engine
  input  wire logic       i_sleep_entry,      // Sleep entry pulse
  input  wire logic       i_first_stimulus_select_arm,        // First stimulus evaluation enable
  // Comparator levels from the analog side
  input  wire logic       i_cmp_vbus_ready,   // Bus voltage ready, async
  input  wire logic       i_cmp_vbus_present, // Bus voltage present, async
  input  wire logic       i_cmp_dp_high,      // Positive line above threshold, async
  input  wire logic       i_cmp_dm_high,      // Negative line above threshold, async
  input  wire logic       i_cmp_dp_low,       // Positive line above fixed low level, async
  // Engine status and response actions
  output logic            o_first_stimulus_select_detect,     // Stimulus seen (filtered)
  output logic            o_first_stimulus_select_done,       // Next stimulus may proceed
  output logic      [3:0] o_resp_mag,         // Applied response magnitude
  output logic            o_dp_volt,          // Voltage on positive_data_line_out
  output logic            o_dm_volt,          // Voltage on negative_data_line_out
  output logic            o_dp_res,           // Resistor positive line to ground
  output logic            o_dm_res,           // Resistor negative line to ground
  output logic            o_dp_div,           // Divider tap on positive line
  output logic            o_dm_div,           // Divider tap on negative line
  output logic            o_dpdm_short        // Low-ohm resistor between lines
);

  // Five comparators; timer wide enough for one millisecond
  localparam int unsigned NCMP = 5;
  localparam int unsigned TW   = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    // Register file, index is address minus base
    logic [11:0][7:0]   regs;
    // Comparator capture chain
    logic [NCMP-1:0]    sync1;
    logic [NCMP-1:0]    sync2;
    logic [NCMP-1:0]    sync3;
    logic [NCMP-1:0]    filt;
    // Millisecond timer
    logic [TW-1:0]      tick_cnt;
    logic [6:0]         ms_left;
    // First stimulus engine
    cep_pkg::cep_state_e state;
    logic [6:0]         drive;
    logic [3:0]         mag;
    logic               done;
    // Host and loader replies
    logic [7:0]         rdata;
    logic               ack;
    logic               reject;
  } cep_state_s;

  cep_state_s st_reg;
  cep_state_s st_next;

  // Action bits: {dp_volt, dm_volt, dp_res, dm_res, dp_div, dm_div, short}
  function automatic logic [6:0] cep_decode(input logic [3:0] code);
    logic [6:0] act;
    act = 7'h00;
    case (code)
      cep_pkg::RSP_V_DP:     act = 7'h40;
      cep_pkg::RSP_V_DM:     act = 7'h20;
      cep_pkg::RSP_V_BOTH:   act = 7'h60;
      cep_pkg::RSP_R_DP:     act = 7'h10;
      cep_pkg::RSP_DIV_DP:   act = 7'h04;
      cep_pkg::RSP_R_DM:     act = 7'h08;
      cep_pkg::RSP_DIV_DM:   act = 7'h02;
      cep_pkg::RSP_SHORT:    act = 7'h01;
      cep_pkg::RSP_DIV_BOTH: act = 7'h06;
      cep_pkg::RSP_R_BOTH:   act = 7'h18;
      // Unusable and keep codes drive nothing
      default:               act = 7'h00;
    endcase
    return act;
  endfunction

  // Profile and loader decode
  logic [3:0]  eff_profile;
  logic        prof_legacy;
  logic        ld_hit;
  logic [3:0]  ld_idx;
  logic        ld_blocked;
  logic        ld_bad;
  // First stimulus settings
  logic [7:0]  cfg1;
  logic [7:0]  resp;
  logic [2:0]  sel;
  logic        tmode;
  logic [6:0]  delay_ms;
  logic        stim;
  logic        nowait;
  logic        tick;
  logic [6:0]  resp_act;
  logic        resp_keep;
  // Host read decode
  logic        rd_hit;
  logic [3:0]  rd_idx;

  always_comb begin
    eff_profile = i_profile_apply ? i_profile_code : st_reg.regs[cep_pkg::IDX_PROFILE][3:0];
    prof_legacy = (eff_profile >= cep_pkg::PROF_LEG_LO) && (eff_profile <= cep_pkg::PROF_LEG_HI);

    ld_hit = (i_ld_addr >= cep_pkg::ADDR_S1_CFG1) && (i_ld_addr <= cep_pkg::ADDR_S3_THRESH);
    ld_idx = 4'(i_ld_addr - cep_pkg::ADDR_BASE);

    ld_blocked = 1'b0;
    if (ld_idx >= cep_pkg::IDX_S3_CFG1) begin
      ld_blocked = prof_legacy || (eff_profile == cep_pkg::PROF_SDP)
                   || (eff_profile == cep_pkg::PROF_DCP);
    end else if (ld_idx == cep_pkg::IDX_S1_THRESH) begin
      ld_blocked = prof_legacy && i_dce_cycle;
    end else if (ld_idx == cep_pkg::IDX_S1_DIVIDER) begin
      ld_blocked = (eff_profile == cep_pkg::PROF_CDP) || (eff_profile == cep_pkg::PROF_DCP);
    end

    // Response registers refuse unusable magnitudes and codes
    ld_bad = 1'b0;
    if ((ld_idx == cep_pkg::IDX_S1_RESP) || (ld_idx == cep_pkg::IDX_S2_RESP)
        || (ld_idx == cep_pkg::IDX_S3_RESP)) begin
      ld_bad = (i_ld_data[cep_pkg::RMAG_LSB +: 4] == cep_pkg::MAG_BAD)
               || (i_ld_data[cep_pkg::RCODE_LSB +: 4] == cep_pkg::RSP_BAD_A)
               || (i_ld_data[cep_pkg::RCODE_LSB +: 4] == cep_pkg::RSP_BAD_B);
    end

    cfg1     = st_reg.regs[cep_pkg::IDX_S1_CFG1];
    resp     = st_reg.regs[cep_pkg::IDX_S1_RESP];
    sel      = cfg1[cep_pkg::SELECT_LSB +: 3];
    tmode    = cfg1[cep_pkg::TMODE_BIT];
    delay_ms = cep_pkg::DELAY_MS[cfg1[cep_pkg::DELAY_LSB +: 3]];

    // Filtered comparators: {dp_low, dm_high, dp_high, vbus_present, vbus_ready}
    case (sel)
      cep_pkg::SEL_VBUS_RDY: stim = st_reg.filt[0];
      cep_pkg::SEL_VBUS_ON:  stim = st_reg.filt[1];
      cep_pkg::SEL_DP_HI_A:  stim = st_reg.filt[2];
      cep_pkg::SEL_DP_HI_B:  stim = st_reg.filt[2];
      cep_pkg::SEL_DM_HI:    stim = st_reg.filt[3];
      cep_pkg::SEL_DP_WIN:   stim = !st_reg.filt[2] && st_reg.filt[4];
      default:               stim = 1'b0;
    endcase
    nowait = (sel == cep_pkg::SEL_VBUS_RDY) || (sel == cep_pkg::SEL_VBUS_ON);

    tick = (st_reg.tick_cnt == TW'(MS_CYCLES - 1));

    // Codes 1110 and 1111 leave whatever is applied unchanged
    resp_keep = (resp[cep_pkg::RCODE_LSB +: 4] >= 4'he);
    resp_act  = cep_decode(resp[cep_pkg::RCODE_LSB +: 4]);

    rd_hit = (i_reg_addr >= cep_pkg::ADDR_PROFILE) && (i_reg_addr <= cep_pkg::ADDR_S3_THRESH);
    rd_idx = 4'(i_reg_addr - cep_pkg::ADDR_BASE);
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack    = 1'b0;
    st_next.reject = 1'b0;

    // Three-stage input capture; a level is taken once stages two and three agree
    st_next.sync1 = {i_cmp_dp_low, i_cmp_dm_high, i_cmp_dp_high,
                     i_cmp_vbus_present, i_cmp_vbus_ready};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < NCMP; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.filt[i] = st_reg.sync3[i];
      end
    end

    // Host access: reads return masked contents, writes are acknowledged and dropped
    if (i_reg_rd || i_reg_wr) begin
      st_next.ack = 1'b1;
    end
    if (i_reg_rd) begin
      if (rd_hit) begin
        st_next.rdata = st_reg.regs[rd_idx] & cep_pkg::REG_MASK[rd_idx];
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    if (i_profile_apply) begin
      st_next.regs[cep_pkg::IDX_PROFILE] = {4'h0, i_profile_code};
    end

    if (i_ld_en && ld_hit) begin
      if (ld_bad) begin
        st_next.reject = 1'b1;
      end else if (!ld_blocked) begin
        st_next.regs[ld_idx] = i_ld_data & cep_pkg::REG_MASK[ld_idx];
      end
    end

    // Timer ticks once per millisecond while a timed phase runs
    if ((st_reg.state == cep_pkg::CEP_DELAY) || (st_reg.state == cep_pkg::CEP_HOLD)) begin
      st_next.tick_cnt = tick ? '0 : TW'(st_reg.tick_cnt + 1'b1);
      // Held at zero so a late tick cannot wrap the count
      if (tick && (st_reg.ms_left != 7'h00)) begin
        st_next.ms_left = 7'(st_reg.ms_left - 1'b1);
      end
    end else begin
      st_next.tick_cnt = '0;
    end

    case (st_reg.state)
      // Nothing is evaluated until armed
      cep_pkg::CEP_IDLE: begin
        st_next.done = 1'b0;
        if (i_first_stimulus_select_arm) begin
          st_next.state = cep_pkg::CEP_WAIT;
        end
      end

      // Timer mode 1 or a zero delay acts at once
      cep_pkg::CEP_WAIT: begin
        if (stim) begin
          st_next.ms_left = delay_ms;
          if (tmode || (delay_ms == 7'h00)) begin
            if (!resp_keep) begin
              st_next.drive = resp_act;
              st_next.mag   = resp[cep_pkg::RMAG_LSB +: 4];
            end
            st_next.state = tmode ? cep_pkg::CEP_HOLD : cep_pkg::CEP_APPLIED;
          end else begin
            st_next.state = cep_pkg::CEP_DELAY;
          end
        end
      end

      // Response waits for the last millisecond tick
      cep_pkg::CEP_DELAY: begin
        if (tick && (st_reg.ms_left <= 7'h01)) begin
          if (!resp_keep) begin
            st_next.drive = resp_act;
            st_next.mag   = resp[cep_pkg::RMAG_LSB +: 4];
          end
          st_next.state = cep_pkg::CEP_APPLIED;
        end
      end

      // Response held for the whole timer
      cep_pkg::CEP_HOLD: begin
        if (st_reg.ms_left == 7'h00) begin
          if (!stim) begin
            st_next.drive = 7'h00;
            st_next.state = cep_pkg::CEP_DONE;
          end else begin
            st_next.state = cep_pkg::CEP_APPLIED;
          end
        end
      end

      // Bus voltage stimuli never wait for removal
      cep_pkg::CEP_APPLIED: begin
        if (nowait) begin
          st_next.state = cep_pkg::CEP_DONE;
        end else if (!stim) begin
          if (tmode) begin
            st_next.drive = 7'h00;
          end
          st_next.state = cep_pkg::CEP_DONE;
        end
      end

      // Done stands until disarm, profile change or sleep
      cep_pkg::CEP_DONE: begin
        st_next.done = 1'b1;
      end
      default: begin
        st_next.state = cep_pkg::CEP_IDLE;
      end
    endcase

    // Dropping the arm or changing profile restarts evaluation; drive is kept until a new response
    if (!i_first_stimulus_select_arm || i_profile_apply) begin
      st_next.state = cep_pkg::CEP_IDLE;
      st_next.done  = 1'b0;
    end

    // Sleep entry wins over a same-cycle load so the volatile registers really end cleared
    // Only the volatile registers are touched; all others keep their contents
    if (i_sleep_entry) begin
      st_next.regs[cep_pkg::IDX_PROFILE] = cep_pkg::REG_RESET[cep_pkg::IDX_PROFILE];
      st_next.regs[cep_pkg::IDX_S1_CFG1] = cep_pkg::REG_RESET[cep_pkg::IDX_S1_CFG1];
      st_next.regs[cep_pkg::IDX_S2_CFG1] = cep_pkg::REG_RESET[cep_pkg::IDX_S2_CFG1];
      st_next.regs[cep_pkg::IDX_S3_CFG1] = cep_pkg::REG_RESET[cep_pkg::IDX_S3_CFG1];
      st_next.state = cep_pkg::CEP_IDLE;
      st_next.done  = 1'b0;
      st_next.drive = 7'h00;
      st_next.mag   = 4'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg.regs     <= cep_pkg::REG_RESET;
      st_reg.sync1    <= '0;
      st_reg.sync2    <= '0;
      st_reg.sync3    <= '0;
      st_reg.filt     <= '0;
      st_reg.tick_cnt <= '0;
      st_reg.ms_left  <= 7'h00;
      // Engine idle with no response applied
      st_reg.state    <= cep_pkg::CEP_IDLE;
      st_reg.drive    <= 7'h00;
      st_reg.mag      <= 4'h0;
      st_reg.done     <= 1'b0;
      st_reg.rdata    <= 8'h00;
      st_reg.ack      <= 1'b0;
      st_reg.reject   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_reg_rdata    = st_reg.rdata;
  assign o_reg_ack      = st_reg.ack;
  assign o_ld_reject    = st_reg.reject;
  assign o_first_stimulus_select_detect = stim;
  assign o_first_stimulus_select_done   = st_reg.done;
  assign o_resp_mag     = st_reg.mag;

  // One action bit per pad control, in decode order
  assign o_dp_volt      = st_reg.drive[6];
  assign o_dm_volt      = st_reg.drive[5];
  assign o_dp_res       = st_reg.drive[4];
  assign o_dm_res       = st_reg.drive[3];
  assign o_dp_div       = st_reg.drive[2];
  assign o_dm_div       = st_reg.drive[1];
  assign o_dpdm_short   = st_reg.drive[0];

endmodule

// ===== inc/cep_pkg.sv
package cep_pkg;

  // Clock and millisecond tick
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map
  localparam int unsigned REG_COUNT        = 12;
  localparam logic [7:0]  ADDR_BASE        = 8'h30;
  localparam logic [7:0]  ADDR_PROFILE     = 8'h30;
  localparam logic [7:0]  ADDR_S1_CFG1     = 8'h31;
  localparam logic [7:0]  ADDR_S1_RESP     = 8'h32;
  localparam logic [7:0]  ADDR_S1_THRESH   = 8'h33;
  localparam logic [7:0]  ADDR_S1_DIVIDER  = 8'h34;
  localparam logic [7:0]  ADDR_S2_CFG1     = 8'h35;
  localparam logic [7:0]  ADDR_S2_RESP     = 8'h36;
  localparam logic [7:0]  ADDR_S2_THRESH   = 8'h37;
  localparam logic [7:0]  ADDR_S2_DIVIDER  = 8'h38;
  localparam logic [7:0]  ADDR_S3_CFG1     = 8'h39;
  localparam logic [7:0]  ADDR_S3_RESP     = 8'h3a;
  localparam logic [7:0]  ADDR_S3_THRESH   = 8'h3b;

  // Register indices (address minus base)
  localparam logic [3:0]  IDX_PROFILE      = 4'h0;
  localparam logic [3:0]  IDX_S1_CFG1      = 4'h1;
  localparam logic [3:0]  IDX_S1_RESP      = 4'h2;
  localparam logic [3:0]  IDX_S1_THRESH    = 4'h3;
  localparam logic [3:0]  IDX_S1_DIVIDER   = 4'h4;
  localparam logic [3:0]  IDX_S2_CFG1      = 4'h5;
  localparam logic [3:0]  IDX_S2_RESP      = 4'h6;
  localparam logic [3:0]  IDX_S3_CFG1      = 4'h9;
  localparam logic [3:0]  IDX_S3_RESP      = 4'ha;
  localparam logic [3:0]  IDX_S3_THRESH    = 4'hb;

  // Values after reset, index order 0x3b .. 0x30
  localparam logic [11:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h09,
                                            8'h00, 8'h02, 8'h00, 8'h26, 8'h00, 8'h00};
  // Implemented bits per register
  localparam logic [11:0][7:0] REG_MASK  = {8'h3f, 8'hff, 8'h7f, 8'h07, 8'h3f, 8'hff,
                                            8'h7f, 8'h07, 8'h3f, 8'hff, 8'h7f, 8'h0f};

  // Field positions
  localparam int unsigned PROFILE_LSB   = 0;
  localparam int unsigned TMODE_BIT     = 6;
  localparam int unsigned DELAY_LSB     = 3;
  localparam int unsigned SELECT_LSB    = 0;
  localparam int unsigned RCODE_LSB     = 0;
  localparam int unsigned RMAG_LSB      = 4;

  // Active profile codes
  localparam logic [3:0]  PROF_SDP      = 4'h0;
  localparam logic [3:0]  PROF_CDP      = 4'h1;
  localparam logic [3:0]  PROF_DCP      = 4'h2;
  localparam logic [3:0]  PROF_LEG_LO   = 4'h3;
  localparam logic [3:0]  PROF_LEG_HI   = 4'h9;
  localparam logic [3:0]  PROF_CUSTOM   = 4'ha;

  // Stimulus select codes
  localparam logic [2:0]  SEL_VBUS_RDY  = 3'h0;
  localparam logic [2:0]  SEL_DP_HI_A   = 3'h1;
  localparam logic [2:0]  SEL_DP_WIN    = 3'h2;
  localparam logic [2:0]  SEL_DM_HI     = 3'h3;
  localparam logic [2:0]  SEL_DP_HI_B   = 3'h6;
  localparam logic [2:0]  SEL_VBUS_ON   = 3'h7;

  // Response codes
  localparam logic [3:0]  RSP_REMOVE    = 4'h0;
  localparam logic [3:0]  RSP_V_DP      = 4'h1;
  localparam logic [3:0]  RSP_V_DM      = 4'h2;
  localparam logic [3:0]  RSP_V_BOTH    = 4'h3;
  localparam logic [3:0]  RSP_R_DP      = 4'h4;
  localparam logic [3:0]  RSP_BAD_A     = 4'h5;
  localparam logic [3:0]  RSP_DIV_DP    = 4'h6;
  localparam logic [3:0]  RSP_R_DM      = 4'h7;
  localparam logic [3:0]  RSP_BAD_B     = 4'h8;
  localparam logic [3:0]  RSP_DIV_DM    = 4'h9;
  localparam logic [3:0]  RSP_SHORT     = 4'ha;
  localparam logic [3:0]  RSP_DIV_BOTH  = 4'hc;
  localparam logic [3:0]  RSP_R_BOTH    = 4'hd;
  localparam logic [3:0]  MAG_BAD       = 4'hf;

  // Timer lengths in ms per delay code
  localparam logic [7:0][6:0] DELAY_MS = {7'd100, 7'd80, 7'd40, 7'd20, 7'd10, 7'd5, 7'd1, 7'd0};

  typedef enum logic [2:0] {
    CEP_IDLE    = 3'b000,
    CEP_WAIT    = 3'b001,
    CEP_DELAY   = 3'b010,
    CEP_HOLD    = 3'b011,
    CEP_APPLIED = 3'b100,
    CEP_DONE    = 3'b101
  } cep_state_e;

endpackage

// ===== tb/cep_profile_props.sv
`timescale 1ns/1ps
module cep_profile_props #(
  parameter int unsigned MS_CYCLES = cep_pkg::MS_CYCLES
) (
  input wire logic       i_clk,           // Clock
  input wire logic       i_rst,           // Reset
  input wire logic       i_reg_rd,        // Read strobe
  input wire logic       i_reg_wr,        // Write strobe
  input wire logic [7:0] i_reg_addr,      // Address
  input wire logic [7:0] o_reg_rdata,     // Read data
  input wire logic       o_reg_ack,       // Access done
  input wire logic       i_profile_apply, // Profile change
  input wire logic [3:0] i_profile_code,  // New profile
  input wire logic       i_ld_en,         // Loader strobe
  input wire logic [7:0] i_ld_addr,       // Loader address
  input wire logic [7:0] i_ld_data,       // Loader data
  input wire logic       o_ld_reject,     // Load refused
  input wire logic       i_sleep_entry,   // Sleep entry
  input wire logic       o_first_stimulus_select_done     // Stimulus done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic acc = i_reg_rd || i_reg_wr;
  a_ack_follows: assert property (acc |=> o_reg_ack) else $error("ack missing");
  a_ack_only_access: assert property (!acc |=> !o_reg_ack) else $error("stray ack");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside {[8'h30:8'h3b]}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_profile_high_zero: assert property (i_reg_rd && i_reg_addr == 8'h30 |=> o_reg_rdata[7:4] == 4'h0)
    else $error("profile upper bits set");
  a_reject_cause: assert property (o_ld_reject |-> $past(i_ld_en) && ($past(i_ld_addr) inside {8'h32, 8'h36, 8'h3a}))
    else $error("reject without cause");
  a_reject_bad_mag: assert property (i_ld_en && i_ld_addr == 8'h32 && i_ld_data[7:4] == 4'hf |=> o_ld_reject)
    else $error("unusable magnitude taken");
  a_profile_follows: assert property ((i_profile_apply && !i_sleep_entry) ##1 !(i_profile_apply || i_sleep_entry)
    ##1 (i_reg_rd && i_reg_addr == 8'h30) |=> o_reg_rdata[3:0] == $past(i_profile_code, 3)) else $error("profile stale");
  a_sleep_clears_prof: assert property (i_sleep_entry ##1 !i_profile_apply ##1 (i_reg_rd && i_reg_addr == 8'h30)
    |=> o_reg_rdata == 8'h00) else $error("profile kept in sleep");
  c_reject: cover property (o_ld_reject);
  c_done: cover property (o_first_stimulus_select_done);
  c_sleep_read: cover property (i_sleep_entry ##2 i_reg_rd);
endmodule
bind cep_profile_status cep_profile_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .i_clk, .i_rst, .i_reg_rd, .i_reg_wr, .i_reg_addr, .o_reg_rdata, .o_reg_ack, .i_profile_apply,
  .i_profile_code, .i_ld_en, .i_ld_addr, .i_ld_data, .o_ld_reject, .i_sleep_entry, .o_first_stimulus_select_done
);

// ===== tb/cep_host_model.sv
`timescale 1ns/1ps
module cep_host_model (
  input  wire logic       i_clk,   // Clock
  input  wire logic       i_ack,   // Access done
  input  wire logic [7:0] i_rdata, // Read data
  output logic            o_rd,    // Read strobe
  output logic            o_wr,    // Write strobe
  output logic      [7:0] o_addr,  // Address
  output logic      [7:0] o_wdata  // Write data
);
  initial {o_rd, o_wr, o_addr, o_wdata} = 18'h00000;
  // One-cycle strobe: a held strobe would be taken as a second access
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge i_clk);
    {o_rd, o_wr, o_addr, o_wdata} = {!wr, wr, a, d};
    @(negedge i_clk);
    {o_rd, o_wr} = 2'b00;
    n = 0;
    while (i_ack !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    q = (i_ack === 1'b1) ? i_rdata : 8'hxx;
    {o_addr, o_wdata} = {~a, ~d};
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  // Short millisecond so a 10 ms delay costs 40 cycles
  localparam int unsigned MSC = 4;
  logic       i_clk = 1'b0, i_rst = 1'b1, i_profile_apply = 1'b0, i_dce_cycle = 1'b0, i_ld_en = 1'b0;
  logic       i_sleep_entry = 1'b0, i_first_stimulus_select_arm = 1'b0, i_reg_rd, i_reg_wr, o_reg_ack, o_ld_reject;
  logic       o_first_stimulus_select_detect, o_first_stimulus_select_done, o_dp_volt, o_dm_volt, o_dp_res, o_dm_res, o_dp_div, o_dm_div, o_dpdm_short;
  logic [4:0] cmp = 5'h00;
  logic [3:0] i_profile_code = 4'h0, o_resp_mag;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_ld_addr = 8'h00, i_ld_data = 8'h00;
  int         num_errors = 0, n_compared = 0;
  always #25 i_clk = ~i_clk;
  cep_profile_status #(.MS_CYCLES(MSC)) dut (
    .i_clk, .i_rst, .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_ack,
    .i_profile_apply, .i_profile_code, .i_dce_cycle, .i_ld_en, .i_ld_addr, .i_ld_data, .o_ld_reject,
    .i_sleep_entry, .i_first_stimulus_select_arm, .i_cmp_vbus_ready(cmp[4]), .i_cmp_vbus_present(cmp[3]),
    .i_cmp_dp_high(cmp[2]), .i_cmp_dm_high(cmp[1]), .i_cmp_dp_low(cmp[0]), .o_first_stimulus_select_detect, .o_first_stimulus_select_done,
    .o_resp_mag, .o_dp_volt, .o_dm_volt, .o_dp_res, .o_dm_res, .o_dp_div, .o_dm_div, .o_dpdm_short
  );
  cep_host_model host (.i_clk, .i_ack(o_reg_ack), .i_rdata(o_reg_rdata), .o_rd(i_reg_rd), .o_wr(i_reg_wr),
    .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    check(what, exp, q);
  endtask
  task automatic ld(input logic [7:0] a, input logic [7:0] d, output logic rej);
    @(negedge i_clk);
    {i_ld_en, i_ld_addr, i_ld_data} = {1'b1, a, d};
    @(negedge i_clk);
    {i_ld_en, i_ld_data} = {1'b0, ~d};
    rej = o_ld_reject;
  endtask
  task automatic ap(input logic [3:0] c);
    @(negedge i_clk);
    {i_profile_apply, i_profile_code} = {1'b1, c};
    @(negedge i_clk);
    i_profile_apply = 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic t_access();
    logic [7:0] q;
    for (int i = 0; i < 12; i++) chk_rd("reset", 8'h30 + 8'(i), cep_pkg::REG_RESET[i]);
    chk_rd("unmapped", 8'h3c, 8'h00);
    host.xfer(1'b1, 8'h32, 8'hff, q);
    chk_rd("written", 8'h32, 8'h26);
    for (int c = 0; c <= 10; c++) begin
      ap(4'(c));
      chk_rd("profile", 8'h30, 8'(c));
    end
    $display("test access done");
  endtask
  task automatic t_loader();
    logic r;
    ap(cep_pkg::PROF_CUSTOM);
    ld(8'h31, 8'hff, r);
    chk_rd("cfg1", 8'h31, 8'h7f);
    ld(8'h32, 8'hf4, r);
    check("reject mag", 8'h01, {7'h0, r});
    ld(8'h32, 8'h25, r);
    check("reject code", 8'h01, {7'h0, r});
    chk_rd("kept", 8'h32, 8'h26);
    ld(8'h32, 8'h3d, r);
    check("accept", 8'h00, {7'h0, r});
    chk_rd("response", 8'h32, 8'h3d);
    ld(8'h39, 8'h11, r);
    ap(cep_pkg::PROF_LEG_LO);
    ld(8'h39, 8'h22, r);
    chk_rd("stim3", 8'h39, 8'h11);
    i_dce_cycle = 1'b1;
    ld(8'h33, 8'h05, r);
    chk_rd("dce frozen", 8'h33, 8'h00);
    i_dce_cycle = 1'b0;
    ld(8'h33, 8'h05, r);
    chk_rd("threshold", 8'h33, 8'h05);
    $display("test loader done");
  endtask
  task automatic t_sleep();
    logic        r;
    logic [15:0] e [7] = '{16'h3000, 16'h3100, 16'h3500, 16'h3900, 16'h3612, 16'h323d, 16'h3305};
    ap(cep_pkg::PROF_CDP);
    ld(8'h31, 8'h09, r);
    ld(8'h35, 8'h0a, r);
    ld(8'h36, 8'h12, r);
    ld(8'h39, 8'h11, r);
    @(negedge i_clk);
    i_sleep_entry = 1'b1;
    @(negedge i_clk);
    i_sleep_entry = 1'b0;
    foreach (e[i]) chk_rd("sleep", e[i][15:8], e[i][7:0]);
    $display("test sleep done");
  endtask
  task automatic t_engine();
    logic       r;
    int         n;
    logic [7:0] acts [6] = '{8'h48, 8'h74, 8'h62, 8'h91, 8'hc3, 8'hdc};
    ap(cep_pkg::PROF_CUSTOM);
    ld(8'h31, 8'h51, r);
    ld(8'h32, 8'h21, r);
    {i_first_stimulus_select_arm, cmp} = {1'b1, 5'h04};
    wait_hi(o_dp_volt, 30, n);
    check("dp drive", 8'h01, {7'h0, o_dp_volt});
    check("magnitude", 8'h02, {4'h0, o_resp_mag});
    cmp = 5'h00;
    repeat (10) @(negedge i_clk);
    check("held", 8'h01, {7'h0, o_dp_volt});
    repeat (20) @(negedge i_clk);
    check("removed", 8'h00, {7'h0, o_dp_volt});
    i_first_stimulus_select_arm = 1'b0;
    ld(8'h31, 8'h19, r);
    ld(8'h32, 8'h22, r);
    {i_first_stimulus_select_arm, cmp} = {1'b1, 5'h04};
    wait_hi(o_first_stimulus_select_detect, 20, n);
    wait_hi(o_dm_volt, 200, n);
    n = n - int'(cep_pkg::DELAY_MS[3]) * MSC;
    check("delay", 8'h01, {7'h0, n >= 0 && n <= 6});
    i_first_stimulus_select_arm = 1'b0;
    ld(8'h31, 8'h40, r);
    ld(8'h32, 8'h0a, r);
    {i_first_stimulus_select_arm, cmp} = {1'b1, 5'h10};
    wait_hi(o_first_stimulus_select_done, 30, n);
    check("done", 8'h01, {7'h0, o_first_stimulus_select_done});
    check("short", 8'h01, {7'h0, o_dpdm_short});
    foreach (acts[i]) begin
      i_first_stimulus_select_arm = 1'b0;
      ld(8'h32, {4'h1, acts[i][7:4]}, r);
      i_first_stimulus_select_arm = 1'b1;
      wait_hi(o_first_stimulus_select_done, 30, n);
      check("action", {4'h0, acts[i][3:0]}, {4'h0, o_dp_res, o_dm_res, o_dp_div, o_dm_div});
    end
    i_first_stimulus_select_arm = 1'b0;
    $display("test engine done");
  endtask
  task automatic t_selects();
    logic       r;
    logic [8:0] t [10] = '{9'h049, 9'h0c5, 9'h0c8, 9'h083, 9'h08a, 9'h189, 9'h13e, 9'h17e, 9'h1d1, 9'h021};
    foreach (t[i]) begin
      cmp = t[i][5:1];
      ld(8'h31, {5'h00, t[i][8:6]}, r);
      // Comparator filter settles within four cycles
      repeat (8) @(negedge i_clk);
      check("detect", {7'h0, t[i][0]}, {7'h0, o_first_stimulus_select_detect});
    end
    $display("test selects done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    t_access();
    t_loader();
    t_sleep();
    t_engine();
    t_selects();
    print_verdict();
  end
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
endmodule
